//--- design/bud_pkg.sv
package bud_pkg;

  // ******************************************************
  // widths and sizes
  // ******************************************************
  localparam int BUD_CNT_W = 16;
  localparam int BUD_NCMP  = 3;
  localparam int BUD_PSC_W = 10;

  // ******************************************************
  // register indices, byte address is four times the index
  // ******************************************************
  localparam logic [5:0] BUD_IDX_CTLA    = 6'h00;
  localparam logic [5:0] BUD_IDX_OVR     = 6'h02;
  localparam logic [5:0] BUD_IDX_ECLR    = 6'h04;
  localparam logic [5:0] BUD_IDX_ESET    = 6'h05;
  localparam logic [5:0] BUD_IDX_FLAGS   = 6'h06;
  localparam logic [5:0] BUD_IDX_EVCTL   = 6'h07;
  localparam logic [5:0] BUD_IDX_CNT     = 6'h08;
  localparam logic [5:0] BUD_IDX_PER     = 6'h09;
  localparam logic [5:0] BUD_IDX_PERIOD_BUFFER  = 6'h0a;
  localparam logic [5:0] BUD_IDX_CMP0    = 6'h0b;
  localparam logic [5:0] BUD_IDX_CMPBUF0 = 6'h0e;

  // ******************************************************
  // field positions
  // ******************************************************
  localparam int BUD_EN_BIT   = 0;
  localparam int BUD_SEL_LSB  = 1;
  localparam int BUD_DIR_BIT  = 0;
  localparam int BUD_LOCK_BIT = 1;
  localparam int BUD_CMD_LSB  = 2;

  // ******************************************************
  // values after reset and bus answers
  // ******************************************************
  localparam logic [15:0] BUD_CNT_RST = 16'h0000;
  localparam logic [15:0] BUD_PER_RST = 16'hffff;
  localparam logic [15:0] BUD_CMP_RST = 16'h0000;
  localparam logic [2:0]  BUD_OVR_RST = 3'h0;
  localparam logic [9:0]  BUD_PSC_RST = 10'h000;
  localparam logic [1:0]  BUD_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  BUD_RESP_SLVERR = 2'h2;

  // ******************************************************
  // types
  // ******************************************************
  typedef enum logic [1:0] {
    BUD_CMD_NONE    = 2'b00,
    BUD_CMD_UPDATE  = 2'b01,
    BUD_CMD_RESTART = 2'b10,
    BUD_CMD_RESET   = 2'b11
  } bud_cmd_t;

  typedef struct packed {
    logic [2:0] tick_source_select;
    logic       enable;
  } bud_ctla_t;

  typedef struct packed {
    logic update_lock;
    logic dir;
  } bud_ctle_t;

  // ******************************************************
  // functions
  // ******************************************************
  function automatic logic [15:0] bud_merge16(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = data[7:0];
    if (strb[1]) r[15:8] = data[15:8];
    return r;
  endfunction : bud_merge16

  // divide by 1, 2, 4, 8, 16, 64, 256, 1024
  function automatic logic [9:0] bud_div_mask(input logic [2:0] sel);
    logic [9:0] m;
    m = 10'h000;
    unique case (sel)
      3'h0: m = 10'h000;
      3'h1: m = 10'h001;
      3'h2: m = 10'h003;
      3'h3: m = 10'h007;
      3'h4: m = 10'h00f;
      3'h5: m = 10'h03f;
      3'h6: m = 10'h0ff;
      3'h7: m = 10'h3ff;
    endcase
    return m;
  endfunction : bud_div_mask

endpackage : bud_pkg

//--- design/bud_prescaler.sv
`timescale 1ns/10ps
module bud_prescaler
  import bud_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic [2:0] sel,
  output logic            tick
);

  logic [BUD_PSC_W-1:0] psc_r;
  logic [BUD_PSC_W-1:0] mask;

  // ******************************************************
  // free divider, cleared so a fresh period starts whole
  // ******************************************************
  assign mask = bud_div_mask(sel);
  assign tick = ((psc_r & mask) == mask); // [R5]

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      psc_r <= BUD_PSC_RST;
    end else begin
      psc_r <= psc_r + 10'h001;
    end
  end

endmodule : bud_prescaler

//--- design/bud_timer.sv
// Notes on behaviour
// [R1] enable starts counting prescaled ticks toward period
// [R2] event count enable counts event pulses instead
// [R3] count register readable at any time
// [R4] count steps in direction bit toward top/bottom
// [R5] ticks are peripheral clock, optionally divided
// [R6] counting up at top wraps to zero
// [R7] counting down at bottom reloads period
// [R8] count write wins over count/clear/reload
// [R9] direction writable while running
// [R10] period and compares each have buffer
// [R11] buffer valid set on write, cleared on update
// [R12] valid flag marks buffer eligible for copy
// [R13] override bits drive outputs only when disabled; here outputs load only override writes made while disabled
// [R14] clear view: write one clears bit
// [R15] set and clear views read identically
// [R16] command: none, update, restart, hard reset
// [R17] command field always reads zero
// [R18] unlocked: update copies buffers at once
// [R19] locked: update copies nothing
// [R20] direction zero counts up, one down
// [R21] update at wrap, reload, or forced command
// [R22] restart zeroes count, keeps settings
`timescale 1ns/10ps
module bud_timer
  import bud_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        EVENT_IN,
  output logic [2:0]       WAVE_OUT
);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // ******************************************************
  // bus slave, write side
  // ******************************************************
  logic        aw_hold_r;
  logic [7:0]  aw_addr_r;
  logic        w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        do_wr;
  logic [5:0]  wr_idx;
  logic        wr_hit;

  assign S_AXI_AWREADY = !aw_hold_r;
  assign S_AXI_WREADY  = !w_hold_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign do_wr  = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_idx = aw_addr_r[7:2];

  always_comb begin
    wr_hit = 1'b0;
    if (wr_idx == BUD_IDX_CTLA || wr_idx == BUD_IDX_OVR || wr_idx == BUD_IDX_ECLR ||
        wr_idx == BUD_IDX_ESET || wr_idx == BUD_IDX_FLAGS || wr_idx == BUD_IDX_EVCTL ||
        (wr_idx >= BUD_IDX_CNT && wr_idx < BUD_IDX_CMPBUF0 + 6'h03)) begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= BUD_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end else if (do_wr) begin
        aw_hold_r <= 1'b0;
      end
      if (S_AXI_WVALID && !w_hold_r) begin
        w_hold_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end else if (do_wr) begin
        w_hold_r <= 1'b0;
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? BUD_RESP_OKAY : BUD_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ******************************************************
  // write strobes and commands
  // ******************************************************
  bud_ctla_t   ctla_r;
  bud_ctle_t   ctle_r;
  logic        evt_en_r;
  logic [2:0]  ovr_r;
  logic [15:0] cnt_r;
  logic [15:0] per_r;
  logic [15:0] period_buffer_r;
  logic [15:0] cmp_r    [BUD_NCMP];
  logic [15:0] cmpbuf_r [BUD_NCMP];
  logic        pbv_r;
  logic [2:0]  cbv_r;
  logic [2:0]  wave_r;
  logic        wr_cnt;
  logic        wr_per;
  logic        wr_period_buffer;
  logic        wr_eset;
  logic        wr_eclr;
  bud_cmd_t    cmd;
  logic        force_upd;
  logic        restart;
  logic        hard_rst;

  assign wr_cnt    = do_wr && wr_idx == BUD_IDX_CNT;
  assign wr_per    = do_wr && wr_idx == BUD_IDX_PER;
  assign wr_period_buffer = do_wr && wr_idx == BUD_IDX_PERIOD_BUFFER;
  assign wr_eset   = do_wr && wr_idx == BUD_IDX_ESET && w_strb_r[0];
  assign wr_eclr   = do_wr && wr_idx == BUD_IDX_ECLR && w_strb_r[0];
  assign cmd       = (wr_eset || wr_eclr) ? bud_cmd_t'(w_data_r[BUD_CMD_LSB +: 2])
                                          : BUD_CMD_NONE;
  assign force_upd = (cmd == BUD_CMD_UPDATE); // [R16]
  assign restart   = (cmd == BUD_CMD_RESTART); // [R16]
  assign hard_rst  = (cmd == BUD_CMD_RESET) && !ctla_r.enable; // [R16]

  // ******************************************************
  // configuration registers
  // ******************************************************
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctla_r   <= '0;
      evt_en_r <= 1'b0;
      ovr_r    <= BUD_OVR_RST;
    end else if (do_wr && w_strb_r[0]) begin
      if (wr_idx == BUD_IDX_CTLA) begin
        ctla_r.enable             <= w_data_r[BUD_EN_BIT]; // [R1]
        ctla_r.tick_source_select <= w_data_r[BUD_SEL_LSB +: 3];
      end
      if (wr_idx == BUD_IDX_EVCTL) begin
        evt_en_r <= w_data_r[0];
      end
      if (wr_idx == BUD_IDX_OVR) begin
        ovr_r <= w_data_r[2:0];
      end
    end
  end

  // no read-modify-write needed for direction or lock
  always_ff @(posedge REF_CLK) begin
    if (RST || hard_rst) begin
      ctle_r <= '0;
    end else if (wr_eset) begin
      ctle_r.dir         <= ctle_r.dir | w_data_r[BUD_DIR_BIT]; // [R9]
      ctle_r.update_lock <= ctle_r.update_lock | w_data_r[BUD_LOCK_BIT];
    end else if (wr_eclr) begin
      ctle_r.dir         <= ctle_r.dir & ~w_data_r[BUD_DIR_BIT]; // [R14]
      ctle_r.update_lock <= ctle_r.update_lock & ~w_data_r[BUD_LOCK_BIT]; // [R14]
    end
  end

  // ******************************************************
  // counter
  // ******************************************************
  logic tick;
  logic step;
  logic at_end;
  logic upd;

  bud_prescaler u_psc (
    .clk  (REF_CLK),
    .rst  (RST),
    .clr  (restart || !ctla_r.enable),
    .sel  (ctla_r.tick_source_select),
    .tick (tick)
  );

  assign step   = ctla_r.enable && (evt_en_r ? EVENT_IN : tick); // [R1] [R2]
  assign at_end = ctle_r.dir ? (cnt_r == 16'h0000) : (cnt_r == per_r);
  // a count write steals the wrap, so no update comes from it
  assign upd    = ((step && at_end && !wr_cnt && !restart) || force_upd) &&
                  !ctle_r.update_lock; // [R21] [R18] [R19]

  always_ff @(posedge REF_CLK) begin
    if (RST || hard_rst) begin
      cnt_r <= BUD_CNT_RST;
    end else if (wr_cnt) begin
      cnt_r <= bud_merge16(cnt_r, w_data_r, w_strb_r); // [R8]
    end else if (restart) begin
      cnt_r <= BUD_CNT_RST; // [R22]
    end else if (step) begin
      if (ctle_r.dir) begin
        cnt_r <= at_end ? per_r : cnt_r - 16'h0001; // [R7] [R20] [R4]
      end else begin
        cnt_r <= at_end ? 16'h0000 : cnt_r + 16'h0001; // [R6] [R20] [R4]
      end
    end
  end

  // ******************************************************
  // double buffering
  // ******************************************************
  always_ff @(posedge REF_CLK) begin
    if (RST || hard_rst) begin
      per_r    <= BUD_PER_RST;
      period_buffer_r <= BUD_PER_RST;
      pbv_r    <= 1'b0;
    end else begin
      if (wr_per) begin
        per_r <= bud_merge16(per_r, w_data_r, w_strb_r);
      end else if (upd && pbv_r) begin
        per_r <= period_buffer_r; // [R10] [R12]
      end
      if (wr_period_buffer) begin
        period_buffer_r <= bud_merge16(period_buffer_r, w_data_r, w_strb_r);
      end
      // a buffer write in the update cycle keeps its flag
      if (wr_period_buffer) begin
        pbv_r <= 1'b1; // [R11]
      end else if (upd) begin
        pbv_r <= 1'b0; // [R11]
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || hard_rst) begin
      for (int n = 0; n < BUD_NCMP; n++) begin
        cmp_r[n]    <= BUD_CMP_RST;
        cmpbuf_r[n] <= BUD_CMP_RST;
        cbv_r[n]    <= 1'b0;
      end
    end else begin
      for (int n = 0; n < BUD_NCMP; n++) begin
        if (do_wr && wr_idx == BUD_IDX_CMP0 + 6'(n)) begin
          cmp_r[n] <= bud_merge16(cmp_r[n], w_data_r, w_strb_r);
        end else if (upd && cbv_r[n]) begin
          cmp_r[n] <= cmpbuf_r[n]; // [R10] [R12]
        end
        if (do_wr && wr_idx == BUD_IDX_CMPBUF0 + 6'(n)) begin
          cmpbuf_r[n] <= bud_merge16(cmpbuf_r[n], w_data_r, w_strb_r);
          cbv_r[n]    <= 1'b1; // [R11]
        end else if (upd) begin
          cbv_r[n] <= 1'b0; // [R11]
        end
      end
    end
  end

  // ******************************************************
  // waveform outputs
  // ******************************************************
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wave_r <= BUD_OVR_RST;
    end else if (!ctla_r.enable) begin
      if (do_wr && wr_idx == BUD_IDX_OVR && w_strb_r[0]) begin
        wave_r <= w_data_r[2:0]; // [R13]
      end
    end else if (step) begin
      for (int n = 0; n < BUD_NCMP; n++) begin
        if (cnt_r == cmp_r[n]) begin
          wave_r[n] <= ~wave_r[n];
        end
      end
    end
  end

  assign WAVE_OUT = wave_r;

  // ******************************************************
  // bus slave, read side
  // ******************************************************
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [5:0]  rd_idx;

  assign rd_idx        = S_AXI_ARADDR[7:2];
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (rd_idx == BUD_IDX_CTLA) begin
      rd_val[3:0] = ctla_r;
    end else if (rd_idx == BUD_IDX_OVR) begin
      rd_val[2:0] = ovr_r;
    end else if (rd_idx == BUD_IDX_ECLR || rd_idx == BUD_IDX_ESET) begin
      rd_val[1:0] = ctle_r; // [R15] [R17]
    end else if (rd_idx == BUD_IDX_FLAGS) begin
      rd_val[3:0] = {cbv_r, pbv_r};
    end else if (rd_idx == BUD_IDX_EVCTL) begin
      rd_val[0] = evt_en_r;
    end else if (rd_idx == BUD_IDX_CNT) begin
      rd_val[15:0] = cnt_r; // [R3]
    end else if (rd_idx == BUD_IDX_PER) begin
      rd_val[15:0] = per_r;
    end else if (rd_idx == BUD_IDX_PERIOD_BUFFER) begin
      rd_val[15:0] = period_buffer_r;
    end else if (rd_idx >= BUD_IDX_CMP0 && rd_idx < BUD_IDX_CMPBUF0) begin
      rd_val[15:0] = cmp_r[2'(rd_idx - BUD_IDX_CMP0)];
    end else if (rd_idx >= BUD_IDX_CMPBUF0 && rd_idx < BUD_IDX_CMPBUF0 + 6'h03) begin
      rd_val[15:0] = cmpbuf_r[2'(rd_idx - BUD_IDX_CMPBUF0)];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= BUD_RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_ok ? BUD_RESP_OKAY : BUD_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  AST_WRAP_UP: assert property (step && !ctle_r.dir && cnt_r == per_r && !wr_cnt &&
    !restart && !hard_rst |=> cnt_r == 16'h0000) else $error("no wrap at top"); // [R6]
  AST_RELOAD_DN: assert property (step && ctle_r.dir && cnt_r == 16'h0000 && !wr_cnt &&
    !restart && !hard_rst |=> cnt_r == $past(per_r)) else $error("no reload"); // [R7]
  AST_STEP_UP: assert property (step && !ctle_r.dir && cnt_r != per_r && !wr_cnt &&
    !restart && !hard_rst |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("bad up step"); // [R4]
  AST_HOLD_OFF: assert property (!ctla_r.enable && !wr_cnt && !restart && !hard_rst
    |=> $stable(cnt_r)) else $error("counted while off"); // [R1]
  AST_CNT_WR: assert property (wr_cnt && w_strb_r[1:0] == 2'h3 && !hard_rst
    |=> cnt_r == $past(w_data_r[15:0])) else $error("count write lost"); // [R8]
  AST_BV_SET: assert property (wr_period_buffer && !hard_rst |=> pbv_r)
    else $error("valid flag not set"); // [R11]
  AST_UPD_COPY: assert property (upd && pbv_r && !wr_per && !wr_period_buffer && !hard_rst
    |=> per_r == $past(period_buffer_r) && !pbv_r) else $error("update did not copy"); // [R18]
  AST_LOCKED: assert property (ctle_r.update_lock && !wr_per && !hard_rst
    |=> $stable(per_r)) else $error("copy under lock"); // [R19]
  AST_OVR: assert property (!ctla_r.enable && do_wr && wr_idx == BUD_IDX_OVR &&
    w_strb_r[0] |=> WAVE_OUT == $past(w_data_r[2:0])) else $error("override ignored"); // [R13]
  AST_CMD_ZERO: assert property (S_AXI_RVALID && $rose(S_AXI_RVALID) |->
    S_AXI_RDATA[3:2] == 2'h0 || $past(rd_idx) != BUD_IDX_ESET && $past(rd_idx) !=
    BUD_IDX_ECLR) else $error("command read nonzero"); // [R17]
  AST_RESTART: assert property (restart && !wr_cnt |=> cnt_r == 16'h0000 &&
    $stable(per_r)) else $error("restart failed"); // [R22]

  COV_WRAP: cover property (step && !ctle_r.dir && at_end ##1 cnt_r == 16'h0000);
  COV_RELOAD: cover property (step && ctle_r.dir && at_end);
  COV_UPD_LOCK: cover property (ctle_r.update_lock && step && at_end && pbv_r);
  COV_WRITE: cover property (S_AXI_BVALID && S_AXI_BREADY);

endmodule : bud_timer

//--- sim/bud_timer_test.sv
`timescale 1ns/10ps
module bud_timer_test
  import bud_pkg::*;
;
  // ****************************************
  // clock, reset and bus signals
  // ****************************************
  localparam int LIMIT = 20000;
  localparam int NROWS = 19;
  typedef struct packed {
    logic [7:0]  a;
    logic        wr;
    logic [31:0] wd;
    logic [31:0] ex;
    logic [1:0]  rs;
  } bud_row_t;
  logic        ref_clk = 1'h0;
  logic        rst     = 1'h1;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'h0;
  logic        awready;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'h0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready  = 1'h0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'h0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready  = 1'h0;
  logic        event_in = 1'h0;
  logic [2:0]  wave;
  int          n_errors = 0;
  int          checks   = 0;
  int          cyc      = 0;
  int          divs [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  bud_row_t    rows [NROWS];
  logic [31:0] d;
  logic [1:0]  r;

  bud_timer uut (
    .REF_CLK(ref_clk), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h3), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .EVENT_IN(event_in), .WAVE_OUT(wave)
  );

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // ****************************************
  // closing report and hang guard
  // ****************************************
  task automatic summarize();
    $display("counts: checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      summarize();
    end
  end

  // ****************************************
  // bus tasks and compares
  // ****************************************
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD data t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD resp t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  // address and data offered together, each dropped once taken
  task automatic wrr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'h0;
  endtask : wrr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    v  = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask : rd

  task automatic wrc(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    wrr(a, v, rs);
    chk_resp(rs, BUD_RESP_OKAY);
  endtask : wrc

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    chk_data(v, e);
    chk_resp(rs, BUD_RESP_OKAY);
  endtask : rdc

  // one-cycle event pulses with a gap, so each edge assigns once
  task automatic ev(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      event_in <= 1'h1;
      @(posedge ref_clk);
      event_in <= 1'h0;
    end
  endtask : ev

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rows = '{
      '{8'h00, 1'h0, 32'h0, 32'h0, 2'h0}, '{8'h08, 1'h0, 32'h0, 32'h0, 2'h0},
      '{8'h10, 1'h0, 32'h0, 32'h0, 2'h0}, '{8'h14, 1'h0, 32'h0, 32'h0, 2'h0},
      '{8'h18, 1'h0, 32'h0, 32'h0, 2'h0}, '{8'h1c, 1'h0, 32'h0, 32'h0, 2'h0},
      '{8'h20, 1'h0, 32'h0, 32'h0, 2'h0}, '{8'h24, 1'h0, 32'h0, 32'hffff, 2'h0},
      '{8'h28, 1'h0, 32'h0, 32'hffff, 2'h0}, '{8'h2c, 1'h0, 32'h0, 32'h0, 2'h0},
      '{8'h30, 1'h0, 32'h0, 32'h0, 2'h0}, '{8'h34, 1'h0, 32'h0, 32'h0, 2'h0},
      '{8'h38, 1'h0, 32'h0, 32'h0, 2'h0}, '{8'h3c, 1'h0, 32'h0, 32'h0, 2'h0},
      '{8'h40, 1'h0, 32'h0, 32'h0, 2'h0}, '{8'h44, 1'h0, 32'h0, 32'h0, 2'h2},
      '{8'h04, 1'h1, 32'hdead, 32'h0, 2'h2}, '{8'h30, 1'h1, 32'h1234, 32'h1234, 2'h0},
      '{8'h34, 1'h1, 32'h1234abcd, 32'habcd, 2'h0}};
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wrr(rows[i].a, rows[i].wd, r);
        chk_resp(r, rows[i].rs);
      end
      rd(rows[i].a, d, r);
      chk_data(d, rows[i].ex);
      chk_resp(r, rows[i].rs);
    end
    $display("test done: register table");
    wrc(8'h24, 32'h3);
    wrc(8'h1c, 32'h1);
    wrc(8'h00, 32'h1);
    ev(3);
    rdc(8'h20, 32'h3);
    ev(1);
    rdc(8'h20, 32'h0);
    $display("test done: event count up");
    wrc(8'h14, 32'h1);
    rdc(8'h10, 32'h1);
    rdc(8'h14, 32'h1);
    ev(1);
    rdc(8'h20, 32'h3);
    ev(1);
    $display("test done: direction change");
    wrc(8'h28, 32'h5);
    wrc(8'h38, 32'h7);
    rdc(8'h18, 32'h3);
    rdc(8'h24, 32'h3);
    ev(2);
    rdc(8'h18, 32'h3);
    ev(1);
    rdc(8'h24, 32'h5);
    rdc(8'h2c, 32'h7);
    rdc(8'h18, 32'h0);
    $display("test done: update at reload");
    wrc(8'h14, 32'h2);
    wrc(8'h28, 32'h9);
    wrc(8'h14, 32'h4);
    rdc(8'h14, 32'h3);
    rdc(8'h24, 32'h5);
    rdc(8'h18, 32'h1);
    wrc(8'h10, 32'h2);
    rdc(8'h10, 32'h1);
    wrc(8'h10, 32'h4);
    rdc(8'h24, 32'h9);
    rdc(8'h18, 32'h0);
    $display("test done: lock and forced update");
    wrc(8'h20, 32'h2);
    rdc(8'h20, 32'h2);
    wrc(8'h14, 32'h8);
    rdc(8'h20, 32'h0);
    rdc(8'h24, 32'h9);
    rdc(8'h14, 32'h1);
    rdc(8'h00, 32'h1);
    $display("test done: count write and restart");
    wrc(8'h00, 32'h0);
    wrc(8'h08, 32'h5);
    repeat (2) @(posedge ref_clk);
    chk_data({29'h0, wave}, 32'h5);
    wrc(8'h00, 32'h1);
    wrc(8'h08, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk_data({29'h0, wave}, 32'h5);
    $display("test done: output override");
    wrc(8'h14, 32'hc);
    rdc(8'h24, 32'h9);
    wrc(8'h00, 32'h0);
    wrc(8'h14, 32'hc);
    rdc(8'h24, 32'hffff);
    rdc(8'h28, 32'hffff);
    rdc(8'h14, 32'h0);
    rdc(8'h2c, 32'h0);
    $display("test done: hard reset command");
    wrc(8'h1c, 32'h0);
    // slow dividers only: bus latency would blur the small ones
    for (int s = 3; s < 8; s++) begin
      wrc(8'h00, 32'h0);
      wrc(8'h20, 32'h0);
      wrc(8'h00, {28'h0, s[2:0], 1'h1});
      repeat (2 * divs[s] + divs[s] / 2 - 3) @(posedge ref_clk);
      rdc(8'h20, 32'h2);
    end
    $display("test done: prescaler");
    @(posedge ref_clk);
    rst <= 1'h1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    chk_data({29'h0, wave}, 32'h0);
    rdc(8'h24, 32'hffff);
    rdc(8'h00, 32'h0);
    rdc(8'h08, 32'h0);
    $display("test done: reset in mid run");
    summarize();
  end
endmodule : bud_timer_test
